// ---- hdl/scr_cfg.svh ----
// Constants for the thyristor firing control block: timing, scaling, map
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

`define CLK_MHZ 250
`define ANGLE_MAX 12'hFFF
`define ANGLE_HALF 12'h800
`define CODE_FULL 4095
`define FULL_SCALE_MV 5000
`define DEADBAND_MV 1750
`define DEADBAND_CODE \
    ((`DEADBAND_MV * `CODE_FULL + `FULL_SCALE_MV - 1) / `FULL_SCALE_MV)

`define STOP_RAMP_MS 100
`define START_RAMP_MS 400
`define STOP_STEP_CYC ((`STOP_RAMP_MS * 1000 * `CLK_MHZ) / `CODE_FULL)
`define START_STEP_CYC ((`START_RAMP_MS * 1000 * `CLK_MHZ) / `CODE_FULL)
`define FAST_OFF_US 1000
`define FAST_OFF_CYC (`FAST_OFF_US * `CLK_MHZ)

`define PH_OFF_A_UP 12'h000
`define PH_OFF_B_UP 12'h555
`define PH_OFF_C_UP 12'hAAB
`define PH_OFF_A_LO 12'h800
`define PH_OFF_B_LO 12'hD55
`define PH_OFF_C_LO 12'h2AB

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_VREF 8'h08
`define ADDR_IRQ_STATUS 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define ADDR_ANGLE 8'h14

`define CTRL_CLOSED_BIT 0
`define CTRL_AC_BIT 1
`define CTRL_MASTER_BIT 2
`define CTRL_SLAVE_BIT 3
`define CTRL_POT_BIT 4
`define CTRL_AUX_BIT 5
`define CTRL_ACB_BIT 6
`define CTRL_RESET 7'h00
`define VREF_RESET 12'h000
`define IRQ_W 5
`define IRQ_RESET 5'h00

`define KP_SHIFT_V 2
`define KI_SHIFT_V 12
`define KP_SHIFT_I 3
`define KI_SHIFT_I 6

`endif

// ---- hdl/scr_pkg.sv ----
// Types shared by the thyristor firing control block
package scr_pkg;
    typedef enum logic {ST_INHIBIT, ST_RUN} run_state_t;
endpackage

// ---- hdl/sync_bits.sv ----
// Two flip-flop synchroniser for a vector of slow pin levels
module sync_bits #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // sync_bits

// ---- hdl/pi_loop.sv ----
// Proportional-integral regulator with a clamped 12-bit demand output
module pi_loop #(
    parameter int KP_SHIFT = 2,
    parameter int KI_SHIFT = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic [11:0] setpoint,
    input wire logic [11:0] feedback,
    output logic [11:0] demand
);
    logic signed [12:0] err;
    logic signed [27:0] integ;
    logic signed [27:0] sum;

    function automatic logic [11:0] clamp12(input logic signed [27:0] v);
        if (v < 0)
            return 12'h000;
        else if (v > 28'sd4095)
            return 12'hFFF;
        else
            return v[11:0];
    endfunction

    assign err = $signed({1'b0, setpoint}) - $signed({1'b0, feedback});
    assign sum = (28'(err) <<< KP_SHIFT) + (integ >>> KI_SHIFT);

    // Anti-windup: integrator stops while the demand is saturated and the error drives it further into the limit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            integ <= '0;
        else if (hold)
            integ <= '0;
        else if (!((clamp12(sum) == 12'hFFF && err > 0) ||
                   (clamp12(sum) == 12'h000 && err < 0)))
            integ <= integ + 28'(err);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            demand <= 12'h000;
        else if (hold)
            demand <= 12'h000;
        else
            demand <= clamp12(sum);
    end
endmodule // pi_loop

// ---- hdl/scr_firing_ctrl.sv ----
// Thyristor bridge firing control: mode select, ramps, inhibit, gates
//
// Our own choices: the register addresses and the strobed register port.
`include "scr_cfg.svh"
module scr_firing_ctrl #(
    parameter int STOP_STEP_CYC = `STOP_STEP_CYC,
    parameter int START_STEP_CYC = `START_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic enable_input,
    input wire logic soft_stop_input_n,
    input wire logic phase_loss,
    input wire logic over_temp,
    input wire logic phase_locked,
    input wire logic [11:0] delay_command_input,
    input wire logic [11:0] onboard_delay_pot,
    input wire logic [11:0] voltage_feedback,
    input wire logic [11:0] current_feedback,
    input wire logic [11:0] slave_current_ref_in,
    input wire logic [11:0] pll_position,
    output logic [11:0] master_current_ref_out,
    output logic aux_reference_select,
    output logic inhibit_flag_output,
    output logic [2:0] upper_gate_group,
    output logic [2:0] lower_gate_group,
    output logic irq
);
    logic en_s, stop_n_s, ploss_s, otemp_s, lock_s;
    logic [11:0] cmd_s, pot_s, vfb_s, ifb_s, ms_ref_s;
    logic [6:0] ctrl;
    logic [11:0] vref;
    logic [`IRQ_W-1:0] irq_status, irq_mask, events;
    logic [3:0] prev;
    logic prev_at_target;
    scr_pkg::run_state_t state;
    logic [11:0] applied, target, cmd_sel, iref, v_demand, i_demand;
    logic [15:0] step_cnt;
    logic fault, closed, ac_mode, master, slave, loop_hold, at_target;
    logic [11:0] up_off [3], lo_off [3];

    // All pin-level inputs are asynchronous to clk; pll_position is local
    sync_bits #(.W(65)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({enable_input, soft_stop_input_n, phase_loss, over_temp,
                   phase_locked, delay_command_input, onboard_delay_pot,
                   voltage_feedback, current_feedback,
                   slave_current_ref_in}),
        .sync_out({en_s, stop_n_s, ploss_s, otemp_s, lock_s, cmd_s, pot_s,
                   vfb_s, ifb_s, ms_ref_s})
    );

    assign closed = ctrl[`CTRL_CLOSED_BIT];
    assign ac_mode = ctrl[`CTRL_AC_BIT];
    assign master = ctrl[`CTRL_MASTER_BIT];
    assign slave = ctrl[`CTRL_SLAVE_BIT];
    assign fault = !en_s || ploss_s || otemp_s || !lock_s;
    assign loop_hold = !closed || fault;
    assign cmd_sel = ctrl[`CTRL_POT_BIT] ? pot_s : delay_command_input_s();

    function automatic logic [11:0] delay_command_input_s();
        return cmd_s;
    endfunction

    // A slave takes its current reference from the master's voltage loop
    assign iref = (slave && !master) ? ms_ref_s : v_demand;

    pi_loop #(.KP_SHIFT(`KP_SHIFT_V), .KI_SHIFT(`KI_SHIFT_V)) u_vloop (
        .clk(clk),
        .rst_n(rst_n),
        .hold(loop_hold),
        .setpoint(vref),
        .feedback(vfb_s),
        .demand(v_demand)
    );

    pi_loop #(.KP_SHIFT(`KP_SHIFT_I), .KI_SHIFT(`KI_SHIFT_I)) u_iloop (
        .clk(clk),
        .rst_n(rst_n),
        .hold(loop_hold),
        .setpoint(iref),
        .feedback(ifb_s),
        .demand(i_demand)
    );

    // Target delay: larger code means later firing, ANGLE_MAX means none
    always_comb begin
        if (!stop_n_s)
            target = `ANGLE_MAX;
        else if (closed)
            target = `ANGLE_MAX - i_demand;
        else if (!ac_mode && cmd_sel < 12'(`DEADBAND_CODE))
            target = `ANGLE_MAX;
        else
            target = `ANGLE_MAX - cmd_sel;
    end

    assign at_target = (applied == target);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            state <= scr_pkg::ST_INHIBIT;
        else begin
            case (state)
                scr_pkg::ST_INHIBIT: begin
                    if (!fault)
                        state <= scr_pkg::ST_RUN;
                end
                scr_pkg::ST_RUN: begin
                    if (fault)
                        state <= scr_pkg::ST_INHIBIT;
                end
                default: state <= scr_pkg::ST_INHIBIT;
            endcase
        end
    end

    // One code per step; rising delay uses the stop pace, falling the start
    // pace, so a reversal simply walks on from wherever the delay stands
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied <= `ANGLE_MAX;
            step_cnt <= 16'h0000;
        end else if (fault || state != scr_pkg::ST_RUN) begin
            applied <= `ANGLE_MAX;
            step_cnt <= 16'h0000;
        end else if (at_target) begin
            step_cnt <= 16'h0000;
        end else if (applied < target) begin
            if (step_cnt >= 16'(STOP_STEP_CYC - 1)) begin
                applied <= applied + 12'h001;
                step_cnt <= 16'h0000;
            end else
                step_cnt <= step_cnt + 16'h0001;
        end else begin
            if (step_cnt >= 16'(START_STEP_CYC - 1)) begin
                applied <= applied - 12'h001;
                step_cnt <= 16'h0000;
            end else
                step_cnt <= step_cnt + 16'h0001;
        end
    end

    // Gate window: from the delay point to the end of the half cycle
    function automatic logic gate_window(input logic [11:0] pos,
                                         input logic [11:0] off,
                                         input logic [11:0] ang);
        logic [11:0] rel;
        rel = pos - off;
        return (rel >= {1'b0, ang[11:1]}) && (rel < `ANGLE_HALF);
    endfunction

    // ACB rotation swaps the B and C phase offsets
    always_comb begin
        up_off[0] = `PH_OFF_A_UP;
        lo_off[0] = `PH_OFF_A_LO;
        up_off[1] = ctrl[`CTRL_ACB_BIT] ? `PH_OFF_C_UP : `PH_OFF_B_UP;
        lo_off[1] = ctrl[`CTRL_ACB_BIT] ? `PH_OFF_C_LO : `PH_OFF_B_LO;
        up_off[2] = ctrl[`CTRL_ACB_BIT] ? `PH_OFF_B_UP : `PH_OFF_C_UP;
        lo_off[2] = ctrl[`CTRL_ACB_BIT] ? `PH_OFF_B_LO : `PH_OFF_C_LO;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_gate_group <= 3'h0;
            lower_gate_group <= 3'h0;
        end else if (fault || state != scr_pkg::ST_RUN ||
                     applied == `ANGLE_MAX) begin
            upper_gate_group <= 3'h0;
            lower_gate_group <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                upper_gate_group[i] <=
                    gate_window(pll_position, up_off[i], applied);
                lower_gate_group[i] <=
                    gate_window(pll_position, lo_off[i], applied);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            inhibit_flag_output <= 1'b1;
        else
            inhibit_flag_output <= fault || !stop_n_s;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            master_current_ref_out <= 12'h000;
            aux_reference_select <= 1'b0;
        end else begin
            master_current_ref_out <= master ? v_demand : 12'h000;
            aux_reference_select <= ctrl[`CTRL_AUX_BIT];
        end
    end

    // Events: inhibit entry, phase loss, overtemp, lock loss, ramp settled
    assign events = {at_target && !prev_at_target && state == scr_pkg::ST_RUN,
                     prev[0] && !lock_s, otemp_s && !prev[1],
                     ploss_s && !prev[2], fault && !prev[3]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Fault is already up as reset ends, which is no new entry
            prev <= 4'h8;
            prev_at_target <= 1'b0;
        end else begin
            prev <= {fault, ploss_s, otemp_s, lock_s};
            prev_at_target <= at_target;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `CTRL_RESET;
            vref <= `VREF_RESET;
            irq_mask <= `IRQ_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_CTRL)
                ctrl <= reg_wdata[6:0];
            if (reg_addr == `ADDR_VREF)
                vref <= reg_wdata[11:0];
            if (reg_addr == `ADDR_IRQ_MASK)
                irq_mask <= reg_wdata[`IRQ_W-1:0];
        end
    end

    // A new event in the clearing cycle survives the write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            irq_status <= `IRQ_RESET;
        else if (reg_wr && reg_addr == `ADDR_IRQ_STATUS)
            irq_status <= (irq_status & ~reg_wdata[`IRQ_W-1:0]) | events;
        else
            irq_status <= irq_status | events;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd) begin
            case (reg_addr)
                `ADDR_CTRL: reg_rdata <= {25'h0, ctrl};
                `ADDR_STATUS: reg_rdata <= {25'h0, state == scr_pkg::ST_RUN,
                    !stop_n_s, en_s, ploss_s, otemp_s, lock_s, fault};
                `ADDR_VREF: reg_rdata <= {20'h0, vref};
                `ADDR_IRQ_STATUS: reg_rdata <= {27'h0, irq_status};
                `ADDR_IRQ_MASK: reg_rdata <= {27'h0, irq_mask};
                `ADDR_ANGLE: reg_rdata <= {20'h0, applied};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else
            reg_rdata <= 32'h0000_0000;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    gates_fast_off_a: assert property (fault |=>
        upper_gate_group == 3'h0 && lower_gate_group == 3'h0)
        else $error("gates still driven during a fault");
    enable_gate_a: assert property (!en_s |=>
        (upper_gate_group | lower_gate_group) == 3'h0)
        else $error("gates driven with enable low");
    phase_loss_off_a: assert property ($rose(ploss_s) |=>
        state == scr_pkg::ST_INHIBIT && applied == `ANGLE_MAX)
        else $error("phase loss did not force turn-off");
    inhibit_flag_a: assert property (fault |=> inhibit_flag_output)
        else $error("inhibit flag low during a fault");
    run_flag_low_a: assert property (!fault && stop_n_s |=>
        !inhibit_flag_output)
        else $error("inhibit flag high in normal running");
    startup_max_a: assert property (state == scr_pkg::ST_INHIBIT |=>
        applied == `ANGLE_MAX)
        else $error("delay not held at maximum before lock");
    deadband_a: assert property (stop_n_s && !closed && !ac_mode &&
        cmd_sel < 12'(`DEADBAND_CODE) |-> target == `ANGLE_MAX)
        else $error("converter conducts inside the deadband");
    open_loop_a: assert property (stop_n_s && !closed &&
        (ac_mode || cmd_sel >= 12'(`DEADBAND_CODE)) |->
        target == `ANGLE_MAX - cmd_sel)
        else $error("open-loop delay not proportional to command");
    ac_conduct_a: assert property (stop_n_s && !closed && ac_mode &&
        cmd_sel != 12'h000 |-> target != `ANGLE_MAX)
        else $error("AC controller does not conduct above zero");
    closed_loop_a: assert property (stop_n_s && closed |->
        target == `ANGLE_MAX - i_demand)
        else $error("closed loop delay not from current loop");
    slave_ref_a: assert property (slave && !master |->
        iref == ms_ref_s)
        else $error("slave current loop not fed by master");
    soft_stop_a: assert property (!stop_n_s |-> target == `ANGLE_MAX)
        else $error("soft stop does not aim at maximum delay");
    ramp_step_a: assert property (
        !fault && state == scr_pkg::ST_RUN ##1 !fault |->
        applied == $past(applied) || applied == $past(applied) + 12'h001 ||
        applied + 12'h001 == $past(applied))
        else $error("delay jumped instead of ramping");
    phase_pair_a: assert property (
        (upper_gate_group & lower_gate_group) == 3'h0)
        else $error("upper and lower gate of one phase both on");

    soft_stop_c: cover property ($fell(stop_n_s) && state == scr_pkg::ST_RUN);
    fault_entry_c: cover property ($rose(fault) && applied != `ANGLE_MAX);
    ramp_done_c: cover property (events[4]);
    closed_run_c: cover property (closed && upper_gate_group != 3'h0);
endmodule // scr_firing_ctrl

// ---- dv/scr_bridge_model.sv ----
// Three-phase bridge model: mains angle source and gate on-time counters
module scr_bridge_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic [2:0] upper_gate_group,
    input wire logic [2:0] lower_gate_group,
    output logic [11:0] pll_position,
    output int on_count [6]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] gate;
    logic [11:0] mains_angle = 12'h000;
    assign gate = {lower_gate_group, upper_gate_group};
    assign pll_position = mains_angle;
    // Mains keeps turning whatever the firing board does
    always @(posedge clk) begin
        mains_angle <= mains_angle + 12'h001;
    end
    // An unknown gate counts as on, so it can never hide a firing fault
    always @(posedge clk) begin
        for (int i = 0; i < 6; i++) begin
            if (clr) begin
                on_count[i] <= 0;
            end else if (gate[i] !== 1'b0) begin
                on_count[i] <= on_count[i] + 1;
            end
        end
    end
endmodule // scr_bridge_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the thyristor firing control block
`include "scr_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 70000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic enable_input = 1'b0;
    logic soft_stop_input_n = 1'b1;
    logic phase_loss = 1'b0;
    logic over_temp = 1'b0;
    logic phase_locked = 1'b1;
    logic [11:0] delay_command_input = 12'h100;
    logic [11:0] onboard_delay_pot = 12'h000;
    logic [11:0] voltage_feedback = 12'h000;
    logic [11:0] current_feedback = 12'h000;
    logic [11:0] slave_current_ref_in = 12'h000;
    logic [11:0] pll_position, master_current_ref_out;
    logic aux_reference_select, inhibit_flag_output, irq;
    logic [2:0] upper_gate_group, lower_gate_group;
    logic clr = 1'b0;
    int on_count [6];
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 80;
    logic [31:0] irq_exp [4] = '{32'h01, 32'h03, 32'h05, 32'h09};

    always #2 clk = ~clk;

    scr_firing_ctrl #(.STOP_STEP_CYC(4), .START_STEP_CYC(8))
        i_scr_firing_ctrl (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .enable_input(enable_input), .soft_stop_input_n(soft_stop_input_n),
        .phase_loss(phase_loss), .over_temp(over_temp),
        .phase_locked(phase_locked),
        .delay_command_input(delay_command_input),
        .onboard_delay_pot(onboard_delay_pot),
        .voltage_feedback(voltage_feedback),
        .current_feedback(current_feedback),
        .slave_current_ref_in(slave_current_ref_in),
        .pll_position(pll_position),
        .master_current_ref_out(master_current_ref_out),
        .aux_reference_select(aux_reference_select),
        .inhibit_flag_output(inhibit_flag_output),
        .upper_gate_group(upper_gate_group),
        .lower_gate_group(lower_gate_group), .irq(irq));

    scr_bridge_model i_scr_bridge_model (
        .clk(clk), .clr(clr), .upper_gate_group(upper_gate_group),
        .lower_gate_group(lower_gate_group), .pll_position(pll_position),
        .on_count(on_count));

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    // Conduction width per mains turn for a steady applied delay
    function automatic int on_width(input logic [11:0] ang);
        return (ang == 12'hFFF) ? 0 : 32'h800 - {21'h0, ang[11:1]};
    endfunction

    task automatic gate_chk(input int exp);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        cyc(4096);
        #1;
        for (int i = 0; i < 6; i++) check(on_count[i], exp);
    endtask

    // Polls the applied delay; n is the cycles spent before it matched
    task automatic wait_angle(input logic [11:0] t, input int bound,
                              output int n);
        logic [31:0] d;
        n = 0;
        rd(`ADDR_ANGLE, d);
        while (d[11:0] !== t && n < bound) begin
            rd(`ADDR_ANGLE, d);
            n += 2;
        end
    endtask

    task automatic set_fault(input int i, input logic on);
        case (i)
            0: enable_input <= !on;
            1: phase_loss <= on;
            2: over_temp <= on;
            default: phase_locked <= !on;
        endcase
    endtask

    initial begin
        logic [31:0] d;
        int n;
        cyc(10);
        #1;
        check(inhibit_flag_output, 1'b1);
        check({upper_gate_group, lower_gate_group}, 6'h00);
        rst_n <= 1'b1;
        rdc(`ADDR_ANGLE, 32'hFFF);
        rdc(`ADDR_STATUS, 32'h03);
        d = $random(seed);
        wr(`ADDR_CTRL, d);
        rdc(`ADDR_CTRL, d & 32'h7F);
        wr(`ADDR_VREF, d);
        rdc(`ADDR_VREF, d & 32'hFFF);
        wr(`ADDR_ANGLE, d);
        rdc(`ADDR_ANGLE, 32'hFFF);
        wr(8'h20, d);
        rdc(8'h20, 32'h0);
        $display("Test registers done");

        wr(`ADDR_CTRL, 32'h02);
        wr(`ADDR_IRQ_STATUS, 32'h1F);
        enable_input <= 1'b1;
        n = 0;
        while (inhibit_flag_output !== 1'b0 && n < 16) begin
            cyc(1);
            n++;
        end
        check(n < 16, 1'b1);
        wait_angle(12'hEFF, 2112, n);
        check(n < 2112, 1'b1);
        rdc(`ADDR_IRQ_STATUS, 32'h10);
        check(irq, 1'b0);
        wr(`ADDR_IRQ_MASK, 32'h10);
        cyc(2);
        check(irq, 1'b1);
        wr(`ADDR_IRQ_STATUS, 32'h10);
        cyc(2);
        check(irq, 1'b0);
        gate_chk(on_width(12'hEFF));
        $display("Test start ramp done");

        wr(`ADDR_CTRL, 32'h00);
        cyc(1200);
        gate_chk(0);
        onboard_delay_pot <= 12'h200;
        delay_command_input <= 12'h000;
        wr(`ADDR_CTRL, 32'h12);
        wait_angle(12'hDFF, 4200, n);
        check(n < 4200, 1'b1);
        gate_chk(on_width(12'hDFF));
        $display("Test deadband and pot done");

        wr(`ADDR_IRQ_MASK, 32'h1F);
        for (int i = 0; i < 4; i++) begin
            wr(`ADDR_IRQ_STATUS, 32'h1F);
            set_fault(i, 1'b1);
            cyc(3);
            #1;
            check(inhibit_flag_output, 1'b1);
            gate_chk(0);
            rdc(`ADDR_ANGLE, 32'hFFF);
            rdc(`ADDR_IRQ_STATUS, irq_exp[i]);
            check(irq, 1'b1);
            wr(`ADDR_IRQ_STATUS, 32'h1F);
            cyc(2);
            check(irq, 1'b0);
            set_fault(i, 1'b0);
            cyc(4);
            check(inhibit_flag_output, 1'b0);
        end
        $display("Test faults done");

        wait_angle(12'hDFF, 4200, n);
        soft_stop_input_n <= 1'b0;
        cyc(400);
        check(inhibit_flag_output, 1'b1);
        soft_stop_input_n <= 1'b1;
        rd(`ADDR_ANGLE, d);
        check(d > 32'hDFF && d < 32'hFFF, 1'b1);
        wait_angle(12'hDFF, (d - 32'hDFF) * 8 + 64, n);
        check(n < (d - 32'hDFF) * 8 + 64, 1'b1);
        soft_stop_input_n <= 1'b0;
        cyc(1984);
        rd(`ADDR_ANGLE, d);
        check(d != 32'hFFF, 1'b1);
        cyc(128);
        rdc(`ADDR_ANGLE, 32'hFFF);
        soft_stop_input_n <= 1'b1;
        $display("Test soft stop done");

        wr(`ADDR_VREF, 32'h800);
        wr(`ADDR_CTRL, 32'h25);
        cyc(200);
        check(master_current_ref_out != 12'h000, 1'b1);
        check(aux_reference_select, 1'b1);
        wr(`ADDR_CTRL, 32'h01);
        cyc(3);
        check(master_current_ref_out, 12'h000);
        check(aux_reference_select, 1'b0);
        // Slave follows the master's zero reference, command is ignored
        delay_command_input <= 12'hFFF;
        wr(`ADDR_CTRL, 32'h09);
        cyc(8);
        rd(`ADDR_ANGLE, d);
        n = d;
        cyc(64);
        rd(`ADDR_ANGLE, d);
        check(d > n && d < n + 32, 1'b1);
        $display("Test closed loop done");
        test_done();
    end
endmodule // tb_top
